// File: hdl/liu_regs.svh
// Register offsets, field positions, codes and reset values of the local interrupt unit
`ifndef LIU_REGS_SVH
`define LIU_REGS_SVH

// ==========================================================
// Register window offsets
`define LIU_OFF_ESR 12'h280
`define LIU_OFF_LVT_CORRECTED_ERROR_THRESHOLD_INTERRUPT 12'h2F0
`define LIU_OFF_LVT_BASE 12'h320
`define LIU_LVT_STRIDE 12'h010
`define LIU_OFF_INIT 12'h380
`define LIU_OFF_CUR 12'h390
`define LIU_OFF_DIV 12'h3E0

// ==========================================================
// Vector entries and fields
`define LIU_NUM_LVT 7
`define LIU_IDX_CORRECTED_ERROR_THRESHOLD_INTERRUPT 0
`define LIU_IDX_TIMER 1
`define LIU_IDX_THERM 2
`define LIU_IDX_PERF 3
`define LIU_IDX_LINT0 4
`define LIU_IDX_LOCAL_INTERRUPT_PIN_ONE 5
`define LIU_IDX_ERROR 6
`define LIU_POS_STATUS 12
`define LIU_POS_POL 13
`define LIU_POS_REMOTE 14
`define LIU_POS_TRIG 15
`define LIU_POS_MASK 16
`define LIU_POS_TMODE 17
`define LIU_MODE_FIXED 3'h0
`define LIU_MODE_SMI 3'h2
`define LIU_MODE_NMI 3'h4
`define LIU_MODE_INIT 3'h5
`define LIU_MODE_EXT 3'h7
`define LIU_TM_ONESHOT 2'h0
`define LIU_TM_PERIODIC 2'h1
`define LIU_TM_DEADLINE 2'h2
// Packed entry image: only the mask bit is set, timer mode stays one-shot
`define LIU_LVT_RST 16'h2000
`define LIU_LOWPRIO_SEND_OK 1'b0

`endif

// File: hdl/liu_pkg.sv
// Types shared by the local interrupt unit
package liu_pkg;
  typedef enum {LIU_IDLE, LIU_EXT_ACK, LIU_OFFER} liu_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] vector;
  } liu_offer_t;

  typedef struct packed {
    logic [1:0] tmode;
    logic mask;
    logic trig;
    logic pol;
    logic [2:0] mode;
    logic [7:0] vector;
  } liu_lvt_t;
endpackage : liu_pkg

// File: hdl/liu_core.sv
// Local interrupt unit: vector entries, error status, countdown timer
`timescale 1ns/10ps
`include "liu_regs.svh"

module liu_core import liu_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic reg_mode_instr_i,
  output logic reg_fault_o,
  input wire logic [1:0] lint_i,
  input wire logic corrected_error_threshold_interrupt_i,
  input wire logic thermal_i,
  input wire logic perf_i,
  input wire logic [3:0] serial_err_i,
  input wire logic send_req_i,
  input wire logic send_lowprio_i,
  input wire logic [7:0] send_vector_i,
  output logic send_go_o,
  input wire logic recv_req_i,
  input wire logic [7:0] recv_vector_i,
  output logic irq_valid_o,
  output liu_offer_t irq_offer_o,
  input wire logic irq_accept_i,
  output logic ext_ack_o,
  input wire logic [7:0] ext_vector_i,
  input wire logic eoi_i,
  input wire logic [7:0] eoi_vector_i
);

  localparam int N = `LIU_NUM_LVT;

  // ==========================================================
  // Address decode
  logic [N-1:0] lvt_hit;
  logic hit_esr, hit_init, hit_cur, hit_div, mapped, any_acc;
  logic [N-1:0] lvt_wr;

  assign hit_esr = reg_addr_i == `LIU_OFF_ESR;
  assign hit_init = reg_addr_i == `LIU_OFF_INIT;
  assign hit_cur = reg_addr_i == `LIU_OFF_CUR;
  assign hit_div = reg_addr_i == `LIU_OFF_DIV;
  assign mapped = (|lvt_hit) | hit_esr | hit_init | hit_cur | hit_div;
  assign any_acc = reg_wr_i | reg_rd_i;
  assign lvt_wr = reg_wr_i ? lvt_hit : '0;

  // ==========================================================
  // Shared state
  liu_state_t state;
  logic [2:0] sel;
  logic [2:0] pick;
  logic pick_any;
  logic [N-1:0] pend, remote, mask_vec, acc_hit, set_pend, rx_ill_lvt, vec_ill_wr;
  logic [N-1:0] src_raw;
  liu_lvt_t cfg [N];
  logic [31:0] lvt_word [N];
  logic [7:0] err_acc, esr_view, err_set, err_next;
  logic err_new, timer_fire, tick;
  logic [31:0] init_count, cur_count;
  logic [2:0] div_sel;
  logic [6:0] presc;
  logic tmode_chg;

  assign src_raw = {err_new, lint_i[1], lint_i[0], perf_i, thermal_i, timer_fire, corrected_error_threshold_interrupt_i};
  assign acc_hit = (state == LIU_OFFER && irq_accept_i) ? 7'(7'h01 << sel) : '0;

  // ==========================================================
  // Per-entry sensing, pending and remote flag
  for (genvar i = 0; i < N; i++) begin : g_lvt
    localparam bit IS_PIN = (i == `LIU_IDX_LINT0) || (i == `LIU_IDX_LOCAL_INTERRUPT_PIN_ONE);
    localparam bit IS_INT = (i == `LIU_IDX_TIMER) || (i == `LIU_IDX_ERROR);
    localparam bit FULL = !((i == `LIU_IDX_CORRECTED_ERROR_THRESHOLD_INTERRUPT) || (i == `LIU_IDX_THERM) ||
                            (i == `LIU_IDX_PERF));
    localparam logic [11:0] OFF = (i == 0) ? `LIU_OFF_LVT_CORRECTED_ERROR_THRESHOLD_INTERRUPT :
                                  12'(`LIU_OFF_LVT_BASE + (i - 1) * `LIU_LVT_STRIDE);
    liu_lvt_t c;
    logic sensed, prev, lvl, mode_ok, illegal, trig_ev;

    assign lvt_hit[i] = reg_addr_i == OFF;
    assign cfg[i] = c;
    assign mask_vec[i] = c.mask;
    assign sensed = src_raw[i] ^ (IS_PIN & c.pol);
    // Forced edge for internal sources and for non-fixed modes other than external; level only on pins
    assign lvl = IS_PIN && ((c.mode == `LIU_MODE_EXT) ||
                            (c.mode == `LIU_MODE_FIXED && c.trig));
    assign mode_ok = (c.mode == `LIU_MODE_FIXED) || (c.mode == `LIU_MODE_SMI) ||
                     (c.mode == `LIU_MODE_NMI) ||
                     (FULL && (c.mode == `LIU_MODE_INIT || c.mode == `LIU_MODE_EXT));
    assign illegal = c.mode == `LIU_MODE_FIXED && c.vector[7:4] == 4'h0;
    // Internal sources are already one-cycle pulses, so no edge detect
    assign trig_ev = IS_INT ? src_raw[i] :
                     lvl ? (sensed & ~remote[i] & ~pend[i]) : (sensed & ~prev);
    assign set_pend[i] = trig_ev & ~c.mask & mode_ok & ~illegal;
    assign rx_ill_lvt[i] = trig_ev & ~c.mask & illegal;
    assign vec_ill_wr[i] = lvt_wr[i] && reg_wdata_i[10:8] == `LIU_MODE_FIXED &&
                           reg_wdata_i[7:4] == 4'h0;
    assign lvt_word[i] = {13'h0000, (i == `LIU_IDX_TIMER) ? c.tmode : 2'h0, c.mask,
                          IS_PIN & c.trig, remote[i], IS_PIN & c.pol, pend[i], 1'b0,
                          c.mode, c.vector};

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        c <= `LIU_LVT_RST;
      end else begin
        if (lvt_wr[i]) begin
          c.vector <= reg_wdata_i[7:0];
          c.mode <= reg_wdata_i[10:8];
          c.pol <= reg_wdata_i[`LIU_POS_POL];
          c.trig <= reg_wdata_i[`LIU_POS_TRIG];
          c.mask <= reg_wdata_i[`LIU_POS_MASK];
          c.tmode <= reg_wdata_i[`LIU_POS_TMODE+1:`LIU_POS_TMODE];
        end
        if (i == `LIU_IDX_PERF && acc_hit[i]) begin
          c.mask <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        prev <= 1'b0;
      end else begin
        prev <= sensed;
      end
    end

    // New request wins over acceptance in the same cycle
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        pend[i] <= 1'b0;
      end else if (set_pend[i]) begin
        pend[i] <= 1'b1;
      end else if (acc_hit[i]) begin
        pend[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        remote[i] <= 1'b0;
      end else if (acc_hit[i] && lvl && c.mode == `LIU_MODE_FIXED) begin
        remote[i] <= 1'b1;
      end else if (eoi_i && eoi_vector_i == c.vector) begin
        remote[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Delivery to the core, lowest entry first
  always_comb begin
    pick = 3'h0;
    pick_any = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pend[k]) begin
        pick = 3'(k);
        pick_any = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= LIU_IDLE;
      sel <= 3'h0;
      irq_offer_o <= '0;
      ext_ack_o <= 1'b0;
    end else begin
      ext_ack_o <= 1'b0;
      unique case (state)
        LIU_IDLE: begin
          if (pick_any) begin
            sel <= pick;
            irq_offer_o.mode <= cfg[pick].mode;
            // Only fixed mode carries the entry's own vector
            irq_offer_o.vector <= (cfg[pick].mode == `LIU_MODE_FIXED) ?
                                  cfg[pick].vector : 8'h00;
            if (cfg[pick].mode == `LIU_MODE_EXT) begin
              ext_ack_o <= 1'b1;
              state <= LIU_EXT_ACK;
            end else begin
              state <= LIU_OFFER;
            end
          end
        end
        LIU_EXT_ACK: begin
          irq_offer_o.vector <= ext_vector_i;
          state <= LIU_OFFER;
        end
        LIU_OFFER: begin
          if (irq_accept_i) begin
            state <= LIU_IDLE;
          end
        end
      endcase
    end
  end

  assign irq_valid_o = state == LIU_OFFER;

  // ==========================================================
  // Error status
  logic redir, send_ill, rx_ill, bad_addr;

  assign redir = send_req_i && send_lowprio_i && !`LIU_LOWPRIO_SEND_OK;
  assign send_ill = send_req_i && !redir && send_vector_i[7:4] == 4'h0;
  // Error entry's own request is excluded: it would loop back into err_new
  assign rx_ill = (|(rx_ill_lvt & ~(7'h01 << `LIU_IDX_ERROR))) || (|vec_ill_wr) ||
                  (recv_req_i && recv_vector_i[7:4] == 4'h0);
  assign bad_addr = any_acc && !mapped && !reg_mode_instr_i;
  assign err_set = {bad_addr, rx_ill, send_ill, redir, serial_err_i};
  assign err_new = |(err_set & ~err_acc);
  assign err_next = err_acc | err_set;

  // Events of the write cycle land in the visible copy, not lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_acc <= 8'h00;
      esr_view <= 8'h00;
    end else if (reg_wr_i && hit_esr) begin
      esr_view <= err_next;
      err_acc <= 8'h00;
    end else begin
      err_acc <= err_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_fault_o <= 1'b0;
      send_go_o <= 1'b0;
    end else begin
      reg_fault_o <= reg_mode_instr_i && any_acc &&
                     (!mapped || (reg_wr_i && hit_esr && reg_wdata_i != 32'h0));
      send_go_o <= send_req_i && !redir && !send_ill;
    end
  end

  // ==========================================================
  // Timer
  logic [6:0] rmask;
  logic deadline;

  assign deadline = cfg[`LIU_IDX_TIMER].tmode == `LIU_TM_DEADLINE;
  assign rmask = 7'((8'h01 << div_sel) - 8'h01);
  assign tick = &(presc | ~rmask);
  assign timer_fire = tick && cur_count == 32'h1 && !(reg_wr_i && hit_init);
  assign tmode_chg = lvt_wr[`LIU_IDX_TIMER] &&
                     reg_wdata_i[`LIU_POS_TMODE+1:`LIU_POS_TMODE] != cfg[`LIU_IDX_TIMER].tmode;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_sel <= 3'h0;
    end else if (reg_wr_i && hit_div) begin
      div_sel <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (reg_wr_i && hit_init)) begin
      presc <= 7'h00;
    end else begin
      presc <= presc + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      init_count <= 32'h0;
      cur_count <= 32'h0;
    end else if (tmode_chg) begin
      cur_count <= 32'h0;
    end else if (reg_wr_i && hit_init && !deadline) begin
      init_count <= reg_wdata_i;
      cur_count <= reg_wdata_i;
    end else if (tick && cur_count != 32'h0) begin
      if (cur_count == 32'h1 && cfg[`LIU_IDX_TIMER].tmode == `LIU_TM_PERIODIC) begin
        cur_count <= init_count;
      end else begin
        cur_count <= cur_count - 32'h1;
      end
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0;
      if (hit_esr) reg_rdata_o <= {24'h000000, esr_view};
      if (hit_init) reg_rdata_o <= init_count;
      if (hit_cur) reg_rdata_o <= cur_count;
      if (hit_div) reg_rdata_o <= {29'h0, div_sel};
      for (int k = 0; k < N; k++) begin
        if (lvt_hit[k]) reg_rdata_o <= lvt_word[k];
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_ext_start;
    state == LIU_IDLE && pick_any && cfg[pick].mode == `LIU_MODE_EXT;
  endsequence
  sequence s_ext_done;
    ext_ack_o ##1 (irq_valid_o && irq_offer_o.vector == $past(ext_vector_i));
  endsequence
  sequence s_esr_write;
    reg_wr_i && hit_esr;
  endsequence

  a_ext_ack_flow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ext_start |=> s_ext_done) else $error("external acknowledge flow broken");
  a_offer_status: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_valid_o |-> pend[sel]) else $error("offer without pending status");
  a_mask_reset: assert property (@(posedge clk_i)
    $past(sys_rst_i) |-> mask_vec == 7'h7F) else $error("masks not set by reset");
  a_no_low_vector: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_valid_o && irq_offer_o.mode == `LIU_MODE_FIXED |-> irq_offer_o.vector[7:4] != 4'h0)
    else $error("illegal vector delivered");
  a_remote_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    acc_hit[`LIU_IDX_LINT0] && cfg[`LIU_IDX_LINT0].mode == `LIU_MODE_FIXED &&
    cfg[`LIU_IDX_LINT0].trig |=> remote[`LIU_IDX_LINT0]) else $error("remote flag not set");
  a_redir_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    redir |-> err_set[4] && !err_set[5] ##1 !send_go_o) else $error("lowest priority send");
  a_esr_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_esr_write |=> esr_view == $past(err_next) && err_acc == 8'h00 || err_new)
    else $error("error register write did not latch");
  a_err_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    err_new && !cfg[`LIU_IDX_ERROR].mask && cfg[`LIU_IDX_ERROR].mode == `LIU_MODE_FIXED &&
    cfg[`LIU_IDX_ERROR].vector[7:4] != 4'h0
    |=> pend[`LIU_IDX_ERROR]) else $error("error interrupt not requested");
  a_oneshot_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timer_fire && cfg[`LIU_IDX_TIMER].tmode == `LIU_TM_ONESHOT && !tmode_chg
    |=> cur_count == 32'h0 && !timer_fire) else $error("one-shot did not stop at zero");
  a_periodic_reload: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    timer_fire && cfg[`LIU_IDX_TIMER].tmode == `LIU_TM_PERIODIC && !tmode_chg
    |=> cur_count == $past(init_count)) else $error("periodic reload missed");
  a_zero_stops: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    reg_wr_i && hit_init && reg_wdata_i == 32'h0 && !deadline && !tmode_chg
    ##1 !(reg_wr_i && hit_init) |-> (cur_count == 32'h0 && !timer_fire))
    else $error("zero write did not stop timer");
  a_masked_timer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cfg[`LIU_IDX_TIMER].mask && !pend[`LIU_IDX_TIMER] |=> !pend[`LIU_IDX_TIMER])
    else $error("masked timer became pending");

endmodule : liu_core

// File: tb/liu_cpu_model.sv
// Core-side partner model: accepts standing offers after a programmable stall
`timescale 1ns/10ps

module liu_cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic irq_valid_i,
  input wire logic [3:0] stall_i,
  output logic irq_accept_o
);
  logic [3:0] wait_cnt;

  // ==========================================================
  // Acceptance
  // One pulse per offer; the stall lets an offer stand long enough to be read back
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_accept_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_accept_o) begin
      irq_accept_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_valid_i) begin
      if (wait_cnt >= stall_i) begin
        irq_accept_o <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : liu_cpu_model

// File: tb/test_local_interrupt_vector_error_timer.sv
// Self-checking bench of the local interrupt unit with a core partner
`timescale 1ns/10ps
`include "liu_regs.svh"

module test_local_interrupt_vector_error_timer import liu_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic instr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [1:0] lint = 2'h0;
  logic corrected_error_threshold_interrupt = 1'b0;
  logic therm = 1'b0;
  logic perf = 1'b0;
  logic [3:0] serr = 4'h0;
  logic snd = 1'b0;
  logic snd_lp = 1'b0;
  logic [7:0] snd_vec = 8'h20;
  logic rcv = 1'b0;
  logic [7:0] rcv_vec = 8'h20;
  logic end_of_service_command = 1'b0;
  logic [7:0] eoi_vec = 8'h20;
  logic [7:0] ext_vec = 8'h20;
  logic [3:0] stall = 4'h0;
  logic [31:0] rdata;
  logic fault, go, valid, acc, ext_ack, rd_q1;
  liu_offer_t offer;
  logic [31:0] rd_exp [$];
  liu_offer_t off_exp [$];
  logic [31:0] rnd = 32'h6468FD52;
  logic [2:0] md [3];
  logic [7:0] v;
  int failures = 0;
  int samples_checked = 0;
  int n_fault = 0;
  int n_go = 0;
  int n_ack = 0;
  int cyc = 0;
  int acc_cyc = 0;
  int t0, a0, i;

  always #5 clk = ~clk;

  liu_core u_dut (.clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_mode_instr_i(instr),
    .reg_fault_o(fault), .lint_i(lint), .corrected_error_threshold_interrupt_i(corrected_error_threshold_interrupt), .thermal_i(therm), .perf_i(perf),
    .serial_err_i(serr), .send_req_i(snd), .send_lowprio_i(snd_lp), .send_vector_i(snd_vec),
    .send_go_o(go), .recv_req_i(rcv), .recv_vector_i(rcv_vec), .irq_valid_o(valid),
    .irq_offer_o(offer), .irq_accept_i(acc), .ext_ack_o(ext_ack), .ext_vector_i(ext_vec),
    .eoi_i(end_of_service_command), .eoi_vector_i(eoi_vec));

  liu_cpu_model u_cpu (.clk_i(clk), .sys_rst_i(rst), .irq_valid_i(valid), .stall_i(stall),
    .irq_accept_o(acc));

  // ==========================================================
  // Comparison and reporting
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp32

  task automatic cmp_off(input liu_offer_t g, input liu_offer_t e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t offer got %h exp %h", $time, g, e);
    end
  endtask : cmp_off

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // Read data lands one cycle after the read edge; 7FF marks an offer nobody expected
  always @(posedge clk) begin
    cyc++;
    rd_q1 <= rd_s;
    if (rd_q1) cmp32(rdata, rd_exp.pop_front());
    if (valid === 1'b1 && acc === 1'b1) begin
      acc_cyc = cyc;
      if (off_exp.size() == 0) cmp_off(offer, 11'h7FF);
      else cmp_off(offer, off_exp.pop_front());
    end
    if (fault === 1'b1) n_fault++;
    if (go === 1'b1) n_go++;
    if (ext_ack === 1'b1) n_ack++;
  end

  // ==========================================================
  // Stimulus helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] rv();
    rnd = lfsr(rnd);
    return {1'b1, rnd[6:0]};
  endfunction : rv

  function automatic logic [11:0] ent(input int k);
    return (k == 0) ? `LIU_OFF_LVT_CORRECTED_ERROR_THRESHOLD_INTERRUPT : `LIU_OFF_LVT_BASE + `LIU_LVT_STRIDE * 12'(k - 1);
  endfunction : ent

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    rd_exp.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd

  task automatic error_status(input logic [31:0] e);
    wr(`LIU_OFF_ESR, 32'h0);
    rd(`LIU_OFF_ESR, e);
  endtask : error_status

  task automatic send(input logic lp, input logic [7:0] vec);
    @(posedge clk);
    snd <= 1'b1;
    snd_lp <= lp;
    snd_vec <= vec;
    @(posedge clk);
    snd <= 1'b0;
  endtask : send

  task automatic recv(input logic [7:0] vec);
    @(posedge clk);
    rcv <= 1'b1;
    rcv_vec <= vec;
    @(posedge clk);
    rcv <= 1'b0;
  endtask : recv

  task automatic end_svc(input logic [7:0] vec);
    @(posedge clk);
    end_of_service_command <= 1'b1;
    eoi_vec <= vec;
    @(posedge clk);
    end_of_service_command <= 1'b0;
  endtask : end_svc

  task automatic set_pin(input logic [1:0] p);
    @(posedge clk);
    lint <= p;
  endtask : set_pin

  // Bounded wait for every expected offer to be taken by the core
  task automatic drain();
    int k;
    for (k = 0; k < 400 && off_exp.size() != 0; k++) @(posedge clk);
    if (off_exp.size() != 0) begin
      failures++;
      report_and_stop();
    end
    tick(2);
  endtask : drain

  task automatic done(input string s);
    $display("test %s finished, failures so far %0d", s, failures);
  endtask : done

  // ==========================================================
  // Main sequence
  initial begin
    md = '{`LIU_MODE_SMI, `LIU_MODE_NMI, `LIU_MODE_INIT};
    tick(16);
    rst <= 1'b0;
    for (i = 0; i < `LIU_NUM_LVT; i++) rd(ent(i), 32'h00010000);
    rd(`LIU_OFF_CUR, 32'h0);
    done("reset");
    wr(`LIU_OFF_ESR, 32'h0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      serr <= 4'h1 << i;
      @(posedge clk);
      serr <= 4'h0;
    end
    error_status(32'h0000000F);
    send(1'b1, 8'h05);
    error_status(32'h00000010);
    send(1'b1, 8'h30);
    send(1'b0, 8'h05);
    send(1'b0, 8'h30);
    error_status(32'h00000030);
    cmp32(32'(n_go), 32'h1);
    recv(8'h03);
    recv(8'h10);
    recv(8'h20);
    error_status(32'h00000040);
    rd(12'hFF0, 32'h0);
    error_status(32'h00000080);
    @(posedge clk);
    instr <= 1'b1;
    rd(12'hFF0, 32'h0);
    error_status(32'h0);
    cmp32(32'(n_fault), 32'h1);
    @(posedge clk);
    instr <= 1'b0;
    error_status(32'h0);
    wr(ent(5), 32'h00010005);
    error_status(32'h00000040);
    done("errors");
    v = rv();
    stall <= 4'hA;
    wr(ent(4), {24'h0, v});
    set_pin(2'b01);
    off_exp.push_back({3'h0, v});
    tick(3);
    rd(ent(4), 32'h1000 | v);
    drain();
    set_pin(2'b00);
    rd(ent(4), {24'h0, v});
    v = rv();
    stall <= 4'h0;
    wr(ent(4), 32'h8000 | v);
    set_pin(2'b01);
    off_exp.push_back({3'h0, v});
    drain();
    rd(ent(4), 32'hC000 | v);
    off_exp.push_back({3'h0, v});
    end_svc(v);
    drain();
    set_pin(2'b00);
    end_svc(v);
    rd(ent(4), 32'h8000 | v);
    v = rv();
    set_pin(2'b10);
    wr(ent(5), 32'h2000 | v);
    set_pin(2'b00);
    off_exp.push_back({3'h0, v});
    drain();
    set_pin(2'b10);
    wr(ent(5), 32'h00012020);
    set_pin(2'b00);
    done("pins");
    for (i = 0; i < 3; i++) begin
      wr(ent(4), 32'h8055 | (32'(md[i]) << 8));
      set_pin(2'b01);
      off_exp.push_back({md[i], 8'h00});
      tick(20);
      drain();
      set_pin(2'b00);
    end
    ext_vec <= rv();
    stall <= 4'h8;
    a0 = n_ack;
    wr(ent(4), 32'h00000720);
    set_pin(2'b01);
    tick(4);
    set_pin(2'b00);
    off_exp.push_back({3'h7, ext_vec});
    drain();
    cmp32(32'(n_ack - a0), 32'h1);
    wr(ent(4), 32'h00000620);
    set_pin(2'b01);
    tick(10);
    set_pin(2'b00);
    wr(ent(4), 32'h00010020);
    done("modes");
    stall <= 4'h0;
    wr(`LIU_OFF_DIV, 32'h0);
    wr(ent(1), 32'h00000060);
    wr(`LIU_OFF_INIT, 32'h5);
    off_exp.push_back({3'h0, 8'h60});
    drain();
    tick(10);
    rd(`LIU_OFF_CUR, 32'h0);
    wr(ent(1), 32'h00020060);
    wr(`LIU_OFF_INIT, 32'd20);
    off_exp.push_back({3'h0, 8'h60});
    off_exp.push_back({3'h0, 8'h60});
    drain();
    wr(`LIU_OFF_INIT, 32'h0);
    tick(60);
    rd(`LIU_OFF_CUR, 32'h0);
    wr(`LIU_OFF_CUR, 32'h1234);
    rd(`LIU_OFF_CUR, 32'h0);
    wr(`LIU_OFF_DIV, 32'h3);
    wr(ent(1), 32'h00000060);
    wr(`LIU_OFF_INIT, 32'd200);
    tick(5);
    t0 = cyc;
    wr(`LIU_OFF_INIT, 32'h2);
    off_exp.push_back({3'h0, 8'h60});
    drain();
    cmp32(32'(acc_cyc - t0 >= 16 && acc_cyc - t0 <= 26), 32'h1);
    wr(`LIU_OFF_DIV, 32'h0);
    wr(ent(1), 32'h00010060);
    wr(`LIU_OFF_INIT, 32'h3);
    tick(20);
    rd(`LIU_OFF_CUR, 32'h0);
    wr(ent(1), 32'h00050060);
    wr(`LIU_OFF_INIT, 32'h7);
    rd(`LIU_OFF_INIT, 32'h3);
    done("timer");
    wr(ent(3), 32'h00000070);
    @(posedge clk);
    perf <= 1'b1;
    off_exp.push_back({3'h0, 8'h70});
    drain();
    perf <= 1'b0;
    rd(ent(3), 32'h00010070);
    wr(ent(0), 32'h00000071);
    @(posedge clk);
    corrected_error_threshold_interrupt <= 1'b1;
    off_exp.push_back({3'h0, 8'h71});
    drain();
    corrected_error_threshold_interrupt <= 1'b0;
    wr(ent(2), 32'h00000571);
    @(posedge clk);
    therm <= 1'b1;
    tick(10);
    therm <= 1'b0;
    wr(ent(6), 32'h00000090);
    recv(8'h02);
    off_exp.push_back({3'h0, 8'h90});
    drain();
    error_status(32'h00000040);
    done("sources");
    tick(20);
    if (off_exp.size() != 0) failures++;
    report_and_stop();
  end
endmodule : test_local_interrupt_vector_error_timer
